/* inc/hbpc_pkg.sv */
package hbpc_pkg;
   localparam int NUM_OUT = 11;
   localparam int NUM_BRIDGE = 6;
   localparam int FRAME_BITS = 24;
   localparam int BITCNT_W = 5;
   localparam int CNT_W = 13;
   localparam int CLK_HZ = 25_000_000;
   localparam int HZ_PER_MHZ = 1_000_000;
   localparam int NS_PER_US = 1000;
   localparam int FILTER_US = 32;
   localparam int FILTER_CYC = (FILTER_US * (CLK_HZ / HZ_PER_MHZ));
   localparam int CC_DELAY_NS = 1000;
   localparam int CC_DELAY_CYC =
      (CC_DELAY_NS * (CLK_HZ / HZ_PER_MHZ) + NS_PER_US - 1) / NS_PER_US;
   // On-time is the filter time; off-time scales it to about 12% or 25% duty
   localparam int DUTY12_OFF_FACTOR = 7;
   localparam int DUTY25_OFF_FACTOR = 3;
   localparam int RECOV12_CYC = FILTER_CYC * DUTY12_OFF_FACTOR;
   localparam int RECOV25_CYC = FILTER_CYC * DUTY25_OFF_FACTOR;
   // Frame layout
   localparam int PAGE_LSB = 22;
   localparam logic [1:0] PAGE_DRIVE = 2'h0;
   localparam logic [1:0] PAGE_MODE = 2'h1;
   localparam int DRV_HS_LSB = 0;
   localparam int DRV_LS_LSB = 11;
   localparam int MON_LSB = 17;
   localparam int DUTY_BIT = 19;
   localparam int CLEAR_BIT = 20;
   localparam int MODE_PWM_LSB = 0;
   localparam int MODE_RECOV_LSB = 11;
   // Outputs eight and nine take the second PWM source
   localparam int PWM_B_FIRST = 8;
   localparam int PWM_B_LAST = 9;

   typedef struct packed {
      logic [NUM_OUT-1:0] hs_on;
      logic [NUM_BRIDGE-1:0] ls_on;
      logic [1:0] mon_sel;
      logic duty_12;
      logic [NUM_OUT-1:0] pwm_en;
      logic [NUM_OUT-1:0] recov_en;
   } cfg_t;

   typedef enum logic [1:0] {
      BR_OFF = 2'b00,
      BR_HS = 2'b01,
      BR_LS = 2'b10,
      BR_DEAD = 2'b11
   } br_state_t;

   typedef struct packed {
      br_state_t st;
      logic from_hs;
      logic [CNT_W-1:0] cnt;
   } bridge_t;

   typedef enum logic [1:0] {
      CH_RUN = 2'b00,
      CH_TRIP = 2'b01,
      CH_LATCH = 2'b10
   } ch_state_t;
endpackage

/* design/oc_channel.sv */
`timescale 1ns/1ps
`default_nettype none
module oc_channel #(
   parameter int FILTER_CYC = hbpc_pkg::FILTER_CYC,
   parameter int OFF_12_CYC = hbpc_pkg::RECOV12_CYC,
   parameter int OFF_25_CYC = hbpc_pkg::RECOV25_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic demand,
   input wire logic oc_seen,
   input wire logic recov_en,
   input wire logic duty_12,
   input wire logic clear_status,
   output logic enable,
   output logic flag
);
   typedef struct packed {
      hbpc_pkg::ch_state_t st;
      logic flag;
      logic en;
      logic [hbpc_pkg::CNT_W-1:0] cnt;
   } state_t;

   state_t q, d;
   logic trip;
   logic [hbpc_pkg::CNT_W-1:0] off_last;

   always_comb begin
      d = q;
      trip = 1'h0;
      off_last = duty_12 ? hbpc_pkg::CNT_W'(OFF_12_CYC - 1) :
                           hbpc_pkg::CNT_W'(OFF_25_CYC - 1);
      unique case (q.st)
         hbpc_pkg::CH_RUN: begin
            if (demand && q.en && oc_seen) begin
               if (q.cnt == hbpc_pkg::CNT_W'(FILTER_CYC - 1)) begin
                  trip = 1'h1;
                  d.flag = 1'h1;
                  d.cnt = '0;
                  d.st = recov_en ? hbpc_pkg::CH_TRIP : hbpc_pkg::CH_LATCH;
               end else begin
                  d.cnt = q.cnt + 1'h1;
               end
            end else begin
               // Any gap in the condition restarts qualification
               d.cnt = '0;
            end
         end
         hbpc_pkg::CH_TRIP: begin
            if (!recov_en) begin
               d.st = hbpc_pkg::CH_LATCH;
            end else if (q.cnt == off_last) begin
               d.st = hbpc_pkg::CH_RUN;
               d.cnt = '0;
            end else begin
               d.cnt = q.cnt + 1'h1;
            end
         end
         hbpc_pkg::CH_LATCH: begin
            d.cnt = '0;
         end
         default: begin
            d.st = hbpc_pkg::CH_LATCH;
         end
      endcase
      // A trip in the clearing cycle keeps its flag
      if (clear_status && !trip) begin
         d.flag = 1'h0;
         // A latch entered from CH_TRIP in this very cycle is released too
         if (d.st == hbpc_pkg::CH_LATCH) begin
            d.st = hbpc_pkg::CH_RUN;
            d.cnt = '0;
         end
      end
      d.en = (d.st == hbpc_pkg::CH_RUN);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.st <= hbpc_pkg::CH_RUN;
         q.en <= 1'h1;
      end else begin
         q <= d;
      end
   end

   assign enable = q.en;
   assign flag = q.flag;
endmodule
`default_nettype wire

/* design/half_bridge_protection_control.sv */
`timescale 1ns/1ps
`default_nettype none
module half_bridge_protection_control #(
   parameter int FILTER_CYC = hbpc_pkg::FILTER_CYC,
   parameter int RECOV12_CYC = hbpc_pkg::RECOV12_CYC,
   parameter int RECOV25_CYC = hbpc_pkg::RECOV25_CYC,
   parameter int CC_DELAY_CYC = hbpc_pkg::CC_DELAY_CYC
) (
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire logic SPI_CLK,
   input wire logic CHIP_SELECT_N,
   input wire logic SERIAL_IN,
   output logic SERIAL_OUT,
   output logic SERIAL_OUT_EN,
   input wire logic PWM_A_INPUT,
   input wire logic MONITOR_OR_PWM_B_PIN,
   input wire logic [hbpc_pkg::NUM_OUT-1:0] OC_DETECT,
   output logic [hbpc_pkg::NUM_OUT-1:0] HIGH_SWITCH_ON,
   output logic [hbpc_pkg::NUM_OUT-1:0] HIGH_SWITCH_FAST_OFF,
   output logic [hbpc_pkg::NUM_BRIDGE-1:0] LOW_SWITCH_ON,
   output logic [hbpc_pkg::NUM_BRIDGE-1:0] LOW_SWITCH_FAST_OFF,
   output logic [1:0] MONITOR_SEL,
   output logic [hbpc_pkg::NUM_OUT-1:0] OC_FLAGS
);
   localparam int NO = hbpc_pkg::NUM_OUT;
   localparam int NB = hbpc_pkg::NUM_BRIDGE;
   localparam int FB = hbpc_pkg::FRAME_BITS;

   typedef struct packed {
      logic [2:0] sclk_s;
      logic [2:0] csn_s;
      logic [1:0] sdi_s;
      logic [1:0] pwma_s;
      logic [1:0] pwmb_s;
      logic [NO-1:0] oc_s1;
      logic [NO-1:0] oc_s2;
      logic [FB-1:0] rx;
      logic [FB-1:0] tx;
      logic [hbpc_pkg::BITCNT_W-1:0] bitcnt;
      logic sdo;
      logic sdo_en;
      logic clear;
      hbpc_pkg::cfg_t cfg;
      hbpc_pkg::bridge_t [NB-1:0] br;
      logic [NO-1:0] hs_on;
      logic [NO-1:0] hs_fast;
      logic [NB-1:0] ls_on;
      logic [NB-1:0] ls_fast;
   } state_t;

   state_t q, d;
   logic [NO-1:0] chan_en;
   logic [NO-1:0] chan_flag;
   logic [NO-1:0] want_hs;
   logic [NB-1:0] want_ls;
   logic [NO-1:0] demand;
   logic [NO-1:0] gated_hs;
   logic [NB-1:0] gated_ls;

   // Pulse-width source per output
   function automatic logic pwm_gate(input int idx, input logic pwm_en,
                                     input logic pwm_a, input logic pwm_b);
      logic src;
      src = (idx >= hbpc_pkg::PWM_B_FIRST && idx <= hbpc_pkg::PWM_B_LAST) ?
            pwm_b : pwm_a;
      return !pwm_en || src;
   endfunction

   always_comb begin
      for (int i = 0; i < NO; i++) begin
         want_hs[i] = q.cfg.hs_on[i] &&
                      pwm_gate(i, q.cfg.pwm_en[i], q.pwma_s[1], q.pwmb_s[1]);
      end
      for (int i = 0; i < NB; i++) begin
         want_ls[i] = q.cfg.ls_on[i] &&
                      pwm_gate(i, q.cfg.pwm_en[i], q.pwma_s[1], q.pwmb_s[1]);
      end
      demand = want_hs | {{(NO - NB){1'h0}}, want_ls};
      gated_hs = want_hs & chan_en;
      gated_ls = want_ls & chan_en[NB-1:0];
   end

   genvar g;
   generate
      for (g = 0; g < NO; g++) begin : g_chan
         oc_channel #(
            .FILTER_CYC(FILTER_CYC),
            .OFF_12_CYC(RECOV12_CYC),
            .OFF_25_CYC(RECOV25_CYC)
         ) u_chan (
            .clk(REF_CLK),
            .rst_n(RSTN),
            .demand(demand[g]),
            .oc_seen(q.oc_s2[g]),
            .recov_en(q.cfg.recov_en[g]),
            .duty_12(q.cfg.duty_12),
            .clear_status(q.clear),
            .enable(chan_en[g]),
            .flag(chan_flag[g])
         );
      end
   endgenerate

   always_comb begin
      logic sclk_rise;
      logic sclk_fall;
      logic cs_fall;
      logic cs_rise;
      logic selected;
      logic req_hs;
      logic req_ls;
      sclk_rise = 1'h0;
      sclk_fall = 1'h0;
      cs_fall = 1'h0;
      cs_rise = 1'h0;
      selected = 1'h0;
      req_hs = 1'h0;
      req_ls = 1'h0;
      d = q;
      // Pins pass two stages; the third stage only feeds edge detection
      d.sclk_s = {q.sclk_s[1:0], SPI_CLK};
      d.csn_s = {q.csn_s[1:0], CHIP_SELECT_N};
      d.sdi_s = {q.sdi_s[0], SERIAL_IN};
      d.pwma_s = {q.pwma_s[0], PWM_A_INPUT};
      d.pwmb_s = {q.pwmb_s[0], MONITOR_OR_PWM_B_PIN};
      d.oc_s1 = OC_DETECT;
      d.oc_s2 = q.oc_s1;
      sclk_rise = q.sclk_s[1] && !q.sclk_s[2];
      sclk_fall = !q.sclk_s[1] && q.sclk_s[2];
      cs_fall = !q.csn_s[1] && q.csn_s[2];
      cs_rise = q.csn_s[1] && !q.csn_s[2];
      selected = !q.csn_s[1];
      d.clear = 1'h0;

      if (cs_fall) begin
         d.bitcnt = '0;
         d.tx = {{(FB - NO){1'h0}}, chan_flag};
      end else if (selected && sclk_rise) begin
         d.rx = {q.sdi_s[1], q.rx[FB-1:1]};
         // Saturate so an overlong frame is rejected
         if (q.bitcnt != hbpc_pkg::BITCNT_W'(FB + 1)) begin
            d.bitcnt = q.bitcnt + 1'h1;
         end
      end else if (selected && sclk_fall) begin
         d.tx = {1'h0, q.tx[FB-1:1]};
      end

      if (cs_rise && q.bitcnt == hbpc_pkg::BITCNT_W'(FB)) begin
         if (q.rx[hbpc_pkg::PAGE_LSB +: 2] == hbpc_pkg::PAGE_DRIVE) begin
            d.cfg.hs_on = q.rx[hbpc_pkg::DRV_HS_LSB +: NO];
            d.cfg.ls_on = q.rx[hbpc_pkg::DRV_LS_LSB +: NB];
            d.cfg.mon_sel = q.rx[hbpc_pkg::MON_LSB +: 2];
            d.cfg.duty_12 = q.rx[hbpc_pkg::DUTY_BIT];
            d.clear = q.rx[hbpc_pkg::CLEAR_BIT];
         end else if (q.rx[hbpc_pkg::PAGE_LSB +: 2] == hbpc_pkg::PAGE_MODE) begin
            d.cfg.pwm_en = q.rx[hbpc_pkg::MODE_PWM_LSB +: NO];
            d.cfg.recov_en = q.rx[hbpc_pkg::MODE_RECOV_LSB +: NO];
         end
      end

      // Second stage only, so the enable lines up with the status reload
      d.sdo_en = !q.csn_s[1];
      d.sdo = d.sdo_en && d.tx[0];

      for (int i = 0; i < NB; i++) begin
         // Both sides asked at once is treated as neither
         req_hs = gated_hs[i] && !gated_ls[i];
         req_ls = gated_ls[i] && !gated_hs[i];
         unique case (q.br[i].st)
            hbpc_pkg::BR_OFF: begin
               if (req_hs) begin
                  d.br[i].st = hbpc_pkg::BR_HS;
               end else if (req_ls) begin
                  d.br[i].st = hbpc_pkg::BR_LS;
               end
            end
            hbpc_pkg::BR_HS: begin
               if (!req_hs) begin
                  d.br[i].st = hbpc_pkg::BR_DEAD;
                  d.br[i].from_hs = 1'h1;
                  d.br[i].cnt = '0;
               end
            end
            hbpc_pkg::BR_LS: begin
               if (!req_ls) begin
                  d.br[i].st = hbpc_pkg::BR_DEAD;
                  d.br[i].from_hs = 1'h0;
                  d.br[i].cnt = '0;
               end
            end
            hbpc_pkg::BR_DEAD: begin
               if (q.br[i].cnt == hbpc_pkg::CNT_W'(CC_DELAY_CYC - 1)) begin
                  d.br[i].st = hbpc_pkg::BR_OFF;
               end else begin
                  d.br[i].cnt = q.br[i].cnt + 1'h1;
               end
            end
         endcase
         d.hs_on[i] = (d.br[i].st == hbpc_pkg::BR_HS);
         d.ls_on[i] = (d.br[i].st == hbpc_pkg::BR_LS);
         // Slow turn-off during the delay, fast only once it expires
         d.hs_fast[i] = !d.hs_on[i] &&
                        !(d.br[i].st == hbpc_pkg::BR_DEAD && d.br[i].from_hs);
         d.ls_fast[i] = !d.ls_on[i] &&
                        !(d.br[i].st == hbpc_pkg::BR_DEAD && !d.br[i].from_hs);
      end
      for (int i = NB; i < NO; i++) begin
         d.hs_on[i] = gated_hs[i];
         d.hs_fast[i] = !gated_hs[i];
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         q <= '0;
         q.csn_s <= '1;
         q.hs_fast <= '1;
         q.ls_fast <= '1;
      end else begin
         q <= d;
      end
   end

   assign SERIAL_OUT = q.sdo;
   assign SERIAL_OUT_EN = q.sdo_en;
   assign HIGH_SWITCH_ON = q.hs_on;
   assign HIGH_SWITCH_FAST_OFF = q.hs_fast;
   assign LOW_SWITCH_ON = q.ls_on;
   assign LOW_SWITCH_FAST_OFF = q.ls_fast;
   assign MONITOR_SEL = q.cfg.mon_sel;
   assign OC_FLAGS = chan_flag;
endmodule
`default_nettype wire

/* verification/hbpc_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module hbpc_checker #(
   parameter int CC_DELAY_CYC = hbpc_pkg::CC_DELAY_CYC
) (
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire logic CHIP_SELECT_N,
   input wire logic SERIAL_OUT,
   input wire logic SERIAL_OUT_EN,
   input wire logic [10:0] OC_DETECT,
   input wire logic [10:0] HIGH_SWITCH_ON,
   input wire logic [10:0] HIGH_SWITCH_FAST_OFF,
   input wire logic [5:0] LOW_SWITCH_ON,
   input wire logic [10:0] OC_FLAGS
);
   default clocking @(posedge REF_CLK);
   endclocking
   default disable iff (!RSTN);
   // Seven cycles covers the select synchroniser and output register
   property p_oe_idle;
      CHIP_SELECT_N [*7] |-> !SERIAL_OUT_EN;
   endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("sdo driven while idle");
   property p_oe_on;
      !CHIP_SELECT_N [*7] |-> SERIAL_OUT_EN;
   endproperty
   a_oe_on: assert property (p_oe_on) else $error("sdo not driven");
   property p_sdo_low;
      !SERIAL_OUT_EN |-> !SERIAL_OUT;
   endproperty
   a_sdo_low: assert property (p_sdo_low) else $error("sdo not parked");
   property p_no_shoot;
      (HIGH_SWITCH_ON[5:0] & LOW_SWITCH_ON) == 6'h00;
   endproperty
   a_no_shoot: assert property (p_no_shoot) else $error("both switches on");
   property p_dead;
      $rose(LOW_SWITCH_ON[0]) |-> !$past(HIGH_SWITCH_ON[0], CC_DELAY_CYC + 1);
   endproperty
   a_dead: assert property (p_dead) else $error("dead time short");
   property p_fast;
      $rose(HIGH_SWITCH_FAST_OFF[0]) |-> $past(HIGH_SWITCH_ON[0], CC_DELAY_CYC + 1) &&
         !$past(HIGH_SWITCH_ON[0], CC_DELAY_CYC);
   endproperty
   a_fast: assert property (p_fast) else $error("fast off mistimed");
   property p_filter;
      $rose(OC_FLAGS[8]) |-> $past(OC_DETECT[8], 5);
   endproperty
   a_filter: assert property (p_filter) else $error("flag without filter");
   property p_trip_off;
      $rose(OC_FLAGS[8]) |-> ##[0:3] !HIGH_SWITCH_ON[8];
   endproperty
   a_trip_off: assert property (p_trip_off) else $error("no shutoff on trip");
   property p_recov;
      $fell(HIGH_SWITCH_ON[8]) && OC_FLAGS[8] |-> !HIGH_SWITCH_ON[8] [*8];
   endproperty
   a_recov: assert property (p_recov) else $error("restart too early");
endmodule
bind half_bridge_protection_control hbpc_checker #(.CC_DELAY_CYC(CC_DELAY_CYC))
   hbpc_checker_inst (
   .REF_CLK(REF_CLK), .RSTN(RSTN), .CHIP_SELECT_N(CHIP_SELECT_N), .SERIAL_OUT(SERIAL_OUT),
   .SERIAL_OUT_EN(SERIAL_OUT_EN), .OC_DETECT(OC_DETECT), .HIGH_SWITCH_ON(HIGH_SWITCH_ON),
   .HIGH_SWITCH_FAST_OFF(HIGH_SWITCH_FAST_OFF), .LOW_SWITCH_ON(LOW_SWITCH_ON),
   .OC_FLAGS(OC_FLAGS)
);
`default_nettype wire

/* verification/mcu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mcu_model (
   input wire logic clk,
   input wire logic miso,
   input wire logic miso_en,
   output logic sclk,
   output logic chip_select_n,
   output logic mosi,
   output logic pwm_a,
   output logic pwm_b,
   output logic [23:0] rx
);
   initial begin
      sclk = 1'h0;
      chip_select_n = 1'h1;
      mosi = 1'h0;
      pwm_a = 1'h0;
      pwm_b = 1'h0;
      rx = 24'h00_0000;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Six cycles a phase stays clear of the two-stage synchroniser
   task automatic xfer(input logic [23:0] w, input int n, input logic sel);
      tick(1);
      chip_select_n <= ~sel;
      for (int i = 0; i < n; i++) begin
         mosi <= w[i];
         tick(6);
         sclk <= 1'h1;
         rx[i] <= miso_en ? miso : 1'hx;
         tick(6);
         sclk <= 1'h0;
      end
      tick(6);
      chip_select_n <= 1'h1;
      // No pull on the data line once released
      mosi <= ~mosi;
      tick(8);
   endtask
   task automatic set_pwm(input logic a, input logic b);
      tick(1);
      pwm_a <= a;
      pwm_b <= b;
   endtask
endmodule
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int rec12 = 28;
   localparam int rec25 = 12;
   logic ref_clk = 1'h0;
   logic rstn;
   logic [10:0] oc_detect;
   logic sclk, chip_select_n, mosi, pwm_a, pwm_b, sdo, sdo_en;
   logic [10:0] hs_on, hs_fast, flags;
   logic [5:0] ls_on, ls_fast;
   logic [1:0] mon_sel;
   logic [23:0] rx;
   logic [29:0] note_q[$];
   event note_ev;
   int n_errors = 0;
   int compares = 0;
   int t;
   int e;

   always #20 ref_clk = ~ref_clk;

   half_bridge_protection_control #(
      .FILTER_CYC(4), .RECOV12_CYC(rec12), .RECOV25_CYC(rec25), .CC_DELAY_CYC(3)
   ) half_bridge_protection_control_inst (
      .REF_CLK(ref_clk), .RSTN(rstn), .SPI_CLK(sclk), .CHIP_SELECT_N(chip_select_n), .SERIAL_IN(mosi),
      .SERIAL_OUT(sdo), .SERIAL_OUT_EN(sdo_en), .PWM_A_INPUT(pwm_a),
      .MONITOR_OR_PWM_B_PIN(pwm_b), .OC_DETECT(oc_detect), .HIGH_SWITCH_ON(hs_on),
      .HIGH_SWITCH_FAST_OFF(hs_fast), .LOW_SWITCH_ON(ls_on), .LOW_SWITCH_FAST_OFF(ls_fast),
      .MONITOR_SEL(mon_sel), .OC_FLAGS(flags)
   );
   mcu_model mcu_model_inst (
      .clk(ref_clk), .miso(sdo), .miso_en(sdo_en), .sclk(sclk), .chip_select_n(chip_select_n), .mosi(mosi),
      .pwm_a(pwm_a), .pwm_b(pwm_b), .rx(rx)
   );

   task automatic tally_and_finish;
      if (n_errors == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic note(input logic [5:0] ls, input logic [10:0] hs, input logic [10:0] fl);
      @(negedge ref_clk);
      note_q.push_back({ls, hs, fl, 2'h0});
      ->note_ev;
   endtask
   always @(note_ev) begin
      chk({2'h0, ls_on, hs_on, flags, 2'h0}, {2'h0, note_q.pop_front()});
   end
   function automatic logic [23:0] pg0(logic c, logic d, logic [1:0] m, logic [5:0] ls,
                                       logic [10:0] hs);
      return {2'h0, 1'h0, c, d, m, ls, hs};
   endfunction
   task automatic send(input logic [23:0] w);
      mcu_model_inst.xfer(w, 24, 1'h1);
      repeat (12) @(posedge ref_clk);
   endtask
   task automatic wait_hs(input logic v);
      for (int i = 0; i < 300 && hs_on[8] !== v; i++) begin
         @(negedge ref_clk);
      end
   endtask
   task automatic set_oc(input logic v, input int n);
      @(posedge ref_clk);
      oc_detect[8] <= v;
      repeat (n) @(posedge ref_clk);
   endtask

   initial begin
      rstn = 1'h0;
      oc_detect = 11'h000;
      void'($urandom(32'h0ec5_2216));
      repeat (2) @(posedge ref_clk);
      rstn <= 1'h1;
      repeat (3) @(posedge ref_clk);
      note(6'h00, 11'h000, 11'h000);
      for (int m = 0; m < 4; m++) begin
         send(pg0(1'h0, 1'h0, 2'(m), 6'h00, 11'h001));
         chk(32'(mon_sel), 32'(m));
      end
      mcu_model_inst.xfer(24'($urandom), 23, 1'h1);
      mcu_model_inst.xfer(24'($urandom), 24, 1'h0);
      note(6'h00, 11'h001, 11'h000);
      chk({5'h00, hs_fast, 10'h000, ls_fast}, {5'h00, 11'h7fe, 10'h000, 6'h3f});
      send(pg0(1'h0, 1'h0, 2'h0, 6'h01, 11'h000));
      note(6'h01, 11'h000, 11'h000);
      chk({5'h00, hs_fast, 10'h000, ls_fast}, {5'h00, 11'h7ff, 10'h000, 6'h3e});
      send(pg0(1'h0, 1'h0, 2'h0, 6'h01, 11'h001));
      note(6'h00, 11'h000, 11'h000);
      chk({5'h00, hs_fast, 10'h000, ls_fast}, {5'h00, 11'h7ff, 10'h000, 6'h3f});
      send({2'h1, 11'h000, 11'h101});
      send(pg0(1'h0, 1'h0, 2'h0, 6'h00, 11'h101));
      for (int p = 0; p < 4; p++) begin
         mcu_model_inst.set_pwm(p[0], p[1]);
         repeat (10) @(posedge ref_clk);
         note(6'h00, {2'h0, p[1], 7'h00, p[0]}, 11'h000);
      end
      send({2'h1, 11'h000, 11'h000});
      set_oc(1'h1, 2);
      set_oc(1'h0, 10);
      note(6'h00, 11'h101, 11'h000);
      set_oc(1'h1, 20);
      note(6'h00, 11'h001, 11'h100);
      set_oc(1'h0, 40);
      note(6'h00, 11'h001, 11'h100);
      send(pg0(1'h1, 1'h0, 2'h0, 6'h00, 11'h101));
      chk({8'h00, rx}, 32'h0000_0100);
      note(6'h00, 11'h101, 11'h000);
      // Lamp style start: recovery on first, dropped later
      send({2'h1, 11'h100, 11'h000});
      set_oc(1'h1, 1);
      for (int d = 0; d < 2; d++) begin
         send(pg0(1'h0, d[0], 2'h0, 6'h00, 11'h101));
         wait_hs(1'h1);
         wait_hs(1'h0);
         for (t = 0; t < 300 && hs_on[8] === 1'h0; t++) begin
            @(negedge ref_clk);
         end
         e = d ? rec12 : rec25;
         chk(32'(t > e - 2 && t < e + 4), 32'h0000_0001);
      end
      send({2'h1, 11'h000, 11'h000});
      repeat (60) @(posedge ref_clk);
      note(6'h00, 11'h001, 11'h100);
      tally_and_finish();
   end

   // Run needs about 5300 cycles; over seven times that means a hang
   initial begin
      repeat (40000) @(posedge ref_clk);
      n_errors++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
